// ===== pkg/nvirq_pkg.sv
// Shared constants, register map and helper function of the vectored interrupt controller
package nvirq_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 32; // Peripheral request lines
	localparam int ID_W = 5; // Width of a source number
	localparam int PRIO_W = 8; // Stored priority byte
	localparam int PRIO_HW = 3; // Upper bits that take part in arbitration
	localparam int GRP_W = 3; // Grouping field width
	localparam int RUN_W = 4; // Running level, one above the largest priority
	localparam int DEPTH_W = 6; // Nesting depth counter
	localparam int ADDR_W = 7; // Byte address width of the slave

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_EN_SET = 7'h00;
	localparam logic [ADDR_W-1:0] OFS_EN_CLR = 7'h04;
	localparam logic [ADDR_W-1:0] OFS_PEND_SET = 7'h08;
	localparam logic [ADDR_W-1:0] OFS_PEND_CLR = 7'h0C;
	localparam logic [ADDR_W-1:0] OFS_ACTIVE = 7'h10;
	localparam logic [ADDR_W-1:0] OFS_GATE = 7'h14;
	localparam logic [ADDR_W-1:0] OFS_GATE_PREV = 7'h18;
	localparam logic [ADDR_W-1:0] OFS_GROUP = 7'h1C;
	localparam logic [ADDR_W-1:0] OFS_MASK = 7'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h24;
	localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 7'h40;
	localparam logic [ADDR_W-1:0] OFS_PRIO_LAST = 7'h5C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GATE_OPEN_BIT = 0; // Gate register, 1 = open
	localparam int STAT_REQ_BIT = 0; // Status: request to the core
	localparam int STAT_THREAD_BIT = 1; // Status: thread return allowed
	localparam int STAT_ID_LSB = 8; // Status: current winner number
	localparam int STAT_RUN_LSB = 16; // Status: running preempt level
	localparam int STAT_DEPTH_LSB = 24; // Status: nesting depth

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [NUM_SRC-1:0] RST_EN = 32'h0000_0000;
	localparam logic RST_GATE = 1'b1;
	localparam logic [GRP_W-1:0] RST_GROUP = 3'h7;
	localparam logic [PRIO_W-1:0] RST_MASK = 8'h00;
	localparam logic [PRIO_W-1:0] RST_PRIO = 8'h00;
	localparam logic [RUN_W-1:0] THREAD_LEVEL = 4'h8; // No handler running

	// Bus slave states
	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} nvirq_bus_state_t;

	// Preemptable part of a 3-bit priority; settings of 3 and up keep all bits
	function automatic logic [PRIO_HW-1:0] nvirq_group(input logic [PRIO_HW-1:0] p,
		input logic [GRP_W-1:0] g);
		logic [1:0] n;
		n = (g >= 3'h3) ? 2'h3 : g[1:0];
		return p & ~(3'h7 >> n);
	endfunction : nvirq_group

endpackage : nvirq_pkg

// ===== rtl/nvirq_arb.sv
// Priority arbiter: best eligible source, lowest number wins a tie
`timescale 1ns/1ps
module nvirq_arb #(
	parameter int N = 32,
	parameter int W = 3,
	parameter int IDW = 5
) (
	input wire logic [N-1:0] elig,
	input wire logic [N*W-1:0] prio,
	output logic found,
	output logic [IDW-1:0] win_id,
	output logic [W-1:0] win_prio
);

	// ----------------------------------------------------------------
	// Linear scan
	// ----------------------------------------------------------------
	// A strict compare in ascending order keeps the lower number on a tie;
	// a tree would be faster but the scan is easier to reason about
	always_comb begin
		found = 1'b0;
		win_id = '0;
		win_prio = '1;
		for (int i = 0; i < N; i++) begin
			// Take a source only if it beats the best so far
			if (elig[i] && (!found || prio[i*W +: W] < win_prio)) begin
				found = 1'b1;
				win_id = IDW'(i);
				win_prio = prio[i*W +: W];
			end
		end
	end

endmodule : nvirq_arb

// ===== rtl/nvirq_ctrl.sv
// Vectored, nesting interrupt controller with an Avalon-MM register slave
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module nvirq_ctrl #(
	parameter logic [31:0] VECTOR_BASE = 32'h0000_0040 // Handler table base
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [nvirq_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [nvirq_pkg::NUM_SRC-1:0] irq_src,
	output logic irq_req,
	output logic [nvirq_pkg::ID_W-1:0] irq_id,
	output logic [31:0] irq_vector,
	input wire logic irq_ack,
	input wire logic irq_done,
	input wire logic [nvirq_pkg::ID_W-1:0] irq_done_id,
	output logic thread_ok
);
	localparam int N = nvirq_pkg::NUM_SRC;
	localparam int PW = nvirq_pkg::PRIO_W;
	localparam int HW = nvirq_pkg::PRIO_HW;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte enables widened to a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{be[b]}};
		end
		return m;
	endfunction : be_mask
	// One-hot vector for a source number
	function automatic logic [N-1:0] onehot(input logic [nvirq_pkg::ID_W-1:0] id);
		logic [N-1:0] v;
		v = '0;
		v[id] = 1'b1;
		return v;
	endfunction : onehot
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	nvirq_pkg::nvirq_bus_state_t bus_q, bus_d; // Slave handshake
	logic [31:0] rdata_q, rdata_d; // Read data, caught on the first edge
	logic [N-1:0] en_q, en_d; // Per-source enables
	logic gate_q, gate_d; // Global gate to the core
	logic gate_prev_q, gate_prev_d; // 1 = gate was closed before last write
	logic [nvirq_pkg::GRP_W-1:0] grp_q, grp_d; // Preemptable bit count
	logic [PW-1:0] mask_q, mask_d; // Priority mask threshold
	logic [PW-1:0] prio_q [N], prio_d [N]; // Priority bytes
	logic [N-1:0] pend_q, pend_d; // Pending flags
	logic [N-1:0] act_q, act_d; // Active handlers
	logic req_q, req_d; // Request to the core
	logic [nvirq_pkg::ID_W-1:0] id_q, id_d; // Dispatched source
	logic [31:0] vec_q, vec_d; // Dispatched handler address
	// ----------------------------------------------------------------
	// Decode and arbitration nets
	// ----------------------------------------------------------------
	logic commit_wr; // Write takes effect this edge
	logic [31:0] wmask; // Byte lanes of the write
	logic [31:0] wbits; // Write data under the lanes
	logic [N*HW-1:0] prio_hw; // Arbitrated bits, flattened
	logic [N-1:0] elig; // Dispatch candidates
	logic found; // Some candidate exists
	logic [nvirq_pkg::ID_W-1:0] win_id; // Best candidate
	logic [HW-1:0] win_prio; // Its arbitrated priority
	logic [nvirq_pkg::RUN_W-1:0] run_lvl; // Preempt level now running
	logic [nvirq_pkg::DEPTH_W-1:0] depth; // Number of active handlers
	logic accept; // Core takes the dispatched vector
	logic [31:0] status; // Status word
	assign commit_wr = avs_write && (bus_q == nvirq_pkg::BUS_ANSWER);
	assign wmask = be_mask(avs_byteenable);
	assign wbits = avs_writedata & wmask;
	assign accept = irq_ack && req_q;
	// ----------------------------------------------------------------
	// Avalon-MM slave handshake
	// ----------------------------------------------------------------
	// Fixed one wait state: every access answers at its second edge
	always_comb begin
		bus_d = nvirq_pkg::BUS_IDLE;
		case (bus_q)
			nvirq_pkg::BUS_IDLE: begin
				// New request, answer next cycle
				if (avs_read || avs_write) begin
					bus_d = nvirq_pkg::BUS_ANSWER;
				end
			end
			nvirq_pkg::BUS_ANSWER: bus_d = nvirq_pkg::BUS_IDLE;
			default: bus_d = nvirq_pkg::BUS_IDLE;
		endcase
	end
	assign avs_waitrequest = (avs_read || avs_write) && (bus_q != nvirq_pkg::BUS_ANSWER);
	// Read mux, captured while waitrequest is still high
	always_comb begin
		rdata_d = rdata_q;
		if (avs_read && bus_q == nvirq_pkg::BUS_IDLE) begin
			rdata_d = 32'h0000_0000; // Unmapped reads as zero
			case (avs_address)
				nvirq_pkg::OFS_EN_SET, nvirq_pkg::OFS_EN_CLR: rdata_d = en_q;
				nvirq_pkg::OFS_PEND_SET, nvirq_pkg::OFS_PEND_CLR: rdata_d = pend_q;
				nvirq_pkg::OFS_ACTIVE: rdata_d = act_q;
				nvirq_pkg::OFS_GATE: rdata_d[nvirq_pkg::GATE_OPEN_BIT] = gate_q;
				nvirq_pkg::OFS_GATE_PREV: rdata_d[0] = gate_prev_q;
				nvirq_pkg::OFS_GROUP: rdata_d[nvirq_pkg::GRP_W-1:0] = grp_q;
				nvirq_pkg::OFS_MASK: rdata_d[PW-1:0] = mask_q;
				nvirq_pkg::OFS_STATUS: rdata_d = status;
				default: begin
					// Priority window, four bytes to a word
					if (avs_address >= nvirq_pkg::OFS_PRIO_BASE &&
						avs_address <= nvirq_pkg::OFS_PRIO_LAST && avs_address[1:0] == 2'h0) begin
						for (int b = 0; b < 4; b++) begin
							rdata_d[b*8 +: 8] = prio_q[{avs_address[4:2], 2'(b)}];
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_q <= nvirq_pkg::BUS_IDLE;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			rdata_q <= rdata_d;
		end
	end
	assign avs_readdata = rdata_q;
	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Writes land only at the edge where waitrequest is low
	always_comb begin
		en_d = en_q;
		gate_d = gate_q;
		gate_prev_d = gate_prev_q;
		grp_d = grp_q;
		mask_d = mask_q;
		for (int i = 0; i < N; i++) begin
			prio_d[i] = prio_q[i];
		end
		if (commit_wr) begin
			case (avs_address)
				// Enables sit only here; peripheral enables are never touched
				nvirq_pkg::OFS_EN_SET: en_d = en_q | wbits;
				nvirq_pkg::OFS_EN_CLR: en_d = en_q & ~wbits;
				nvirq_pkg::OFS_GATE: begin
					// Gate change keeps the enables; old state kept for software
					if (avs_byteenable[0]) begin
						gate_d = avs_writedata[nvirq_pkg::GATE_OPEN_BIT];
						gate_prev_d = ~gate_q;
					end
				end
				nvirq_pkg::OFS_GROUP: begin
					if (avs_byteenable[0]) begin
						grp_d = avs_writedata[nvirq_pkg::GRP_W-1:0];
					end
				end
				nvirq_pkg::OFS_MASK: begin
					if (avs_byteenable[0]) begin
						mask_d = avs_writedata[PW-1:0];
					end
				end
				default: begin
					// Priority bytes, all eight bits stored
					if (avs_address >= nvirq_pkg::OFS_PRIO_BASE &&
						avs_address <= nvirq_pkg::OFS_PRIO_LAST && avs_address[1:0] == 2'h0) begin
						for (int b = 0; b < 4; b++) begin
							if (avs_byteenable[b]) begin
								prio_d[{avs_address[4:2], 2'(b)}] = avs_writedata[b*8 +: 8];
							end
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= nvirq_pkg::RST_EN;
			gate_q <= nvirq_pkg::RST_GATE;
			gate_prev_q <= ~nvirq_pkg::RST_GATE;
			grp_q <= nvirq_pkg::RST_GROUP;
			mask_q <= nvirq_pkg::RST_MASK;
			for (int i = 0; i < N; i++) begin
				prio_q[i] <= nvirq_pkg::RST_PRIO;
			end
		end else begin
			en_q <= en_d;
			gate_q <= gate_d;
			gate_prev_q <= gate_prev_d;
			grp_q <= grp_d;
			mask_q <= mask_d;
			for (int i = 0; i < N; i++) begin
				prio_q[i] <= prio_d[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Eligibility and running level
	// ----------------------------------------------------------------
	// Only the top three bits of each byte feed the compare
	for (genvar g = 0; g < N; g++) begin : g_src
		assign prio_hw[g*HW +: HW] = prio_q[g][PW-1 -: HW];
		// Masked by enable, by being active, and by the threshold
		assign elig[g] = pend_q[g] && en_q[g] && !act_q[g] &&
			(mask_q[PW-1 -: HW] == 3'h0 || prio_hw[g*HW +: HW] < mask_q[PW-1 -: HW]);
	end

	// Running level: most urgent preempt group among active handlers
	always_comb begin
		run_lvl = nvirq_pkg::THREAD_LEVEL;
		depth = '0;
		for (int i = 0; i < N; i++) begin
			if (act_q[i]) begin
				depth = depth + 6'h01;
				if ({1'b0, nvirq_pkg::nvirq_group(prio_hw[i*HW +: HW], grp_q)} < run_lvl) begin
					run_lvl = {1'b0, nvirq_pkg::nvirq_group(prio_hw[i*HW +: HW], grp_q)};
				end
			end
		end
	end

	// Full three-bit value ranks candidates; subpriority orders the tail chain
	nvirq_arb #(
		.N(N),
		.W(HW),
		.IDW(nvirq_pkg::ID_W)
	) u_arb (
		.elig(elig),
		.prio(prio_hw),
		.found(found),
		.win_id(win_id),
		.win_prio(win_prio)
	);

	// ----------------------------------------------------------------
	// Pending and active tracking
	// ----------------------------------------------------------------
	// A live source beats a software unpend in the same cycle; an accepted
	// source is not re-pended by its live line because it is active from then on
	always_comb begin
		logic [N-1:0] hw_set;
		logic [N-1:0] sw_set;
		logic [N-1:0] sw_clr;
		logic [N-1:0] acc_vec;
		logic [N-1:0] done_vec;
		hw_set = irq_src & en_q & ~act_q;
		sw_set = '0;
		sw_clr = '0;
		if (commit_wr && avs_address == nvirq_pkg::OFS_PEND_SET) begin
			sw_set = wbits;
		end
		if (commit_wr && avs_address == nvirq_pkg::OFS_PEND_CLR) begin
			sw_clr = wbits;
		end
		acc_vec = accept ? onehot(id_q) : '0;
		done_vec = irq_done ? onehot(irq_done_id) : '0;
		pend_d = (pend_q & ~sw_clr & ~acc_vec) | sw_set | (hw_set & ~acc_vec);
		act_d = (act_q & ~done_vec) | acc_vec;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_q <= '0;
			act_q <= '0;
		end else begin
			pend_q <= pend_d;
			act_q <= act_d;
		end
	end

	// ----------------------------------------------------------------
	// Dispatch to the core
	// ----------------------------------------------------------------
	// Request drops the cycle after acceptance so a stale vector is never seen
	always_comb begin
		req_d = gate_q && found &&
			({1'b0, nvirq_pkg::nvirq_group(win_prio, grp_q)} < run_lvl) && !accept;
		id_d = win_id;
		vec_d = VECTOR_BASE + {25'h0, win_id, 2'h0};
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_q <= 1'b0;
			id_q <= '0;
			vec_q <= 32'h0000_0000;
		end else begin
			req_q <= req_d;
			id_q <= id_d;
			vec_q <= vec_d;
		end
	end
	assign irq_req = req_q;
	assign irq_id = id_q;
	assign irq_vector = vec_q;
	// Thread return only once nothing is active and nothing waits
	assign thread_ok = !(|act_q) && !found;
	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	always_comb begin
		status = 32'h0000_0000;
		status[nvirq_pkg::STAT_REQ_BIT] = req_q;
		status[nvirq_pkg::STAT_THREAD_BIT] = thread_ok;
		status[nvirq_pkg::STAT_ID_LSB +: nvirq_pkg::ID_W] = id_q;
		status[nvirq_pkg::STAT_RUN_LSB +: nvirq_pkg::RUN_W] = run_lvl;
		status[nvirq_pkg::STAT_DEPTH_LSB +: nvirq_pkg::DEPTH_W] = depth;
	end
endmodule : nvirq_ctrl

// ===== tb/nvirq_ctrl_assertions.sv
// Port checker of the interrupt controller, bound to its top module
`timescale 1ns/1ps
module nvirq_ctrl_checker #(
	parameter logic [31:0] VECTOR_BASE = 32'h0000_0040 // Handler table base
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [nvirq_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [nvirq_pkg::NUM_SRC-1:0] irq_src,
	input wire logic irq_req,
	input wire logic [nvirq_pkg::ID_W-1:0] irq_id,
	input wire logic [31:0] irq_vector,
	input wire logic irq_ack,
	input wire logic irq_done,
	input wire logic [nvirq_pkg::ID_W-1:0] irq_done_id,
	input wire logic thread_ok
);
	// ------
	// Gate shadow
	// ------
	logic gate_q; // Gate as software last left it
	logic gate_d; // Next shadow value
	// Follows a gate write at the edge where it lands
	always_comb begin
		gate_d = gate_q;
		if (avs_write && !avs_waitrequest && avs_address == nvirq_pkg::OFS_GATE
			&& avs_byteenable[0]) begin
			gate_d = avs_writedata[nvirq_pkg::GATE_OPEN_BIT];
		end
	end
	// Shadow register, open after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_q <= nvirq_pkg::RST_GATE;
		end else begin
			gate_q <= gate_d;
		end
	end
	// ------
	// Properties
	// ------
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_RST_VAL: assert property ($fell(rst) |-> !irq_req && irq_id == 5'h00
		&& avs_readdata == 32'h0) else $error("outputs not cleared by reset");
	AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state in first access cycle");
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("more than one wait state");
	AST_READ_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed outside a read");
	AST_VEC: assert property (irq_req |-> irq_vector == VECTOR_BASE + {25'h0, irq_id, 2'h0})
		else $error("vector does not match winner");
	AST_ACK_DROP: assert property (irq_req && irq_ack |=> !irq_req)
		else $error("request held after accept");
	AST_THREAD_BUSY: assert property ($rose(irq_req) |-> !thread_ok)
		else $error("thread return allowed with a request up");
	AST_THREAD_QUIET: assert property (thread_ok && $past(thread_ok) |-> !irq_req)
		else $error("request while nothing is pending");
	AST_GATE: assert property (!gate_q && !$past(gate_q) |-> !irq_req)
		else $error("request passed a closed gate");
endmodule : nvirq_ctrl_checker

bind nvirq_ctrl nvirq_ctrl_checker #(.VECTOR_BASE(VECTOR_BASE)) i_chk (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_src(irq_src),
	.irq_req(irq_req), .irq_id(irq_id), .irq_vector(irq_vector), .irq_ack(irq_ack),
	.irq_done(irq_done), .irq_done_id(irq_done_id), .thread_ok(thread_ok));

// ===== tb/nvirq_core_model.sv
// Processor core model: takes vectors and ends handlers
`timescale 1ns/1ps
module nvirq_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_req,
	input wire logic [4:0] irq_id,
	input wire logic [31:0] irq_vector,
	input wire logic ack_en, // Core willing to take a vector
	input wire logic [3:0] dly, // Cycles the core dawdles first
	input wire logic done_go, // Bench asks for a handler exit
	input wire logic [4:0] done_sel, // Handler that exits
	output logic irq_ack,
	output logic irq_done,
	output logic [4:0] irq_done_id,
	output logic [7:0] tcnt, // Vectors taken so far
	output logic [4:0] tid, // Last taken source
	output logic [31:0] tvec // Last taken address
);
	logic [3:0] wait_q; // Dawdle counter
	// Accept only while the request stands; one pulse per vector
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_ack <= 1'b0;
			irq_done <= 1'b0;
			irq_done_id <= 5'h00;
			wait_q <= 4'h0;
			tcnt <= 8'h00;
			tid <= 5'h00;
			tvec <= 32'h0;
		end else begin
			irq_ack <= 1'b0;
			if (irq_req && ack_en && !irq_ack) begin
				// Slow core lets the winner change meanwhile
				if (wait_q >= dly) begin
					irq_ack <= 1'b1;
					wait_q <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
			// Record what the controller hands over at the accept edge
			if (irq_ack && irq_req) begin
				tid <= irq_id;
				tvec <= irq_vector;
				tcnt <= tcnt + 8'h01;
			end
			irq_done <= done_go;
			// Idle id toggles so no stale value can pass for a real one
			irq_done_id <= done_go ? done_sel : ~irq_done_id;
		end
	end
endmodule : nvirq_core_model

// ===== tb/tb_top.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] VB = 32'h0000_0040; // Vector base used here
	logic clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [6:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, irq_vector, tvec, rdat;
	logic [31:0] irq_src;
	logic irq_req, irq_ack, irq_done, thread_ok, ack_en, done_go;
	logic [4:0] irq_id, irq_done_id, done_sel, tid;
	logic [3:0] dly;
	logic [7:0] tcnt, seen; // Vectors taken, and expected so
	int error_cnt = 0;
	int compares = 0;
	nvirq_ctrl #(.VECTOR_BASE(VB)) i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq_src(irq_src), .irq_req(irq_req), .irq_id(irq_id), .irq_vector(irq_vector),
		.irq_ack(irq_ack), .irq_done(irq_done), .irq_done_id(irq_done_id),
		.thread_ok(thread_ok));
	nvirq_core_model i_core (.clk(clk), .rst(rst), .irq_req(irq_req), .irq_id(irq_id),
		.irq_vector(irq_vector), .ack_en(ack_en), .dly(dly), .done_go(done_go),
		.done_sel(done_sel), .irq_ack(irq_ack), .irq_done(irq_done),
		.irq_done_id(irq_done_id), .tcnt(tcnt), .tid(tid), .tvec(tvec));
	// ------
	// Clock and tasks
	// ------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		if (error_cnt == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask : chk
	// One bus access, held until waitrequest is seen low at a rising edge;
	// a slave that never answers is left to the watchdog
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
		@(posedge clk);
	endtask : bus
	task automatic rdc(input logic [6:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rdc
	// Next vector taken must be this source, at its table slot
	task automatic take(input logic [4:0] id);
		int n = 0;
		seen++;
		while (tcnt !== seen && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk({24'h0, tcnt}, {24'h0, seen});
		chk({27'h0, tid}, {27'h0, id});
		chk(tvec, VB + {25'h0, id, 2'h0});
		@(posedge clk);
	endtask : take
	// Nothing dispatched for a while
	task automatic none();
		repeat (8) @(posedge clk);
		chk({24'h0, tcnt}, {24'h0, seen});
	endtask : none
	task automatic done(input logic [4:0] id);
		done_sel <= id;
		done_go <= 1'b1;
		@(posedge clk);
		done_go <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : done
	// ------
	// Tests
	// ------
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, done_go} = 3'h0;
		{avs_address, avs_writedata, irq_src, done_sel, dly, seen} = '0;
		ack_en = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(nvirq_pkg::OFS_EN_SET, 32'h0);
		rdc(nvirq_pkg::OFS_GATE, 32'h1);
		rdc(nvirq_pkg::OFS_GROUP, 32'h7);
		rdc(nvirq_pkg::OFS_STATUS, 32'h0008_0002);
		bus(1'b1, 7'h3C, 32'hFFFF_FFFF);
		rdc(7'h3C, 32'h0);
		bus(1'b1, nvirq_pkg::OFS_PRIO_BASE + 7'h04, 32'h3F5A_A51F);
		rdc(nvirq_pkg::OFS_PRIO_BASE + 7'h04, 32'h3F5A_A51F);
		bus(1'b1, nvirq_pkg::OFS_GROUP, 32'h5);
		rdc(nvirq_pkg::OFS_GROUP, 32'h5);
		bus(1'b1, nvirq_pkg::OFS_GROUP, 32'h7);
		bus(1'b1, nvirq_pkg::OFS_EN_SET, 32'h0000_12F0);
		// Equal priority: lower number first, then tail chained
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_1200);
		take(5'd9);
		none();
		done(5'd9);
		take(5'd12);
		done(5'd12);
		// Level 1 beats level 5; lower waits for the running handler
		dly <= 4'h3;
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_00A0);
		take(5'd7);
		none();
		done(5'd7);
		take(5'd5);
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0040);
		take(5'd6);
		rdc(nvirq_pkg::OFS_ACTIVE, 32'h0000_0060);
		rdc(nvirq_pkg::OFS_STATUS, 32'h0202_0000);
		chk(thread_ok, 1'b0);
		done(5'd6);
		done(5'd5);
		chk(thread_ok, 1'b1);
		// One preempt bit: levels 2 and 1 share a group
		dly <= 4'h0;
		bus(1'b1, nvirq_pkg::OFS_GROUP, 32'h1);
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0040);
		take(5'd6);
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0080);
		none();
		done(5'd6);
		take(5'd7);
		done(5'd7);
		bus(1'b1, nvirq_pkg::OFS_GROUP, 32'h7);
		// Threshold at level 2 holds levels 2 and 5 back
		bus(1'b1, nvirq_pkg::OFS_MASK, 32'h40);
		rdc(nvirq_pkg::OFS_MASK, 32'h40);
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0060);
		none();
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0080);
		take(5'd7);
		done(5'd7);
		bus(1'b1, nvirq_pkg::OFS_MASK, 32'h0);
		take(5'd6);
		done(5'd6);
		take(5'd5);
		done(5'd5);
		// Closed gate holds the request; enables and history kept
		bus(1'b1, nvirq_pkg::OFS_GATE, 32'h0);
		rdc(nvirq_pkg::OFS_GATE_PREV, 32'h0);
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0010);
		none();
		rdc(nvirq_pkg::OFS_EN_SET, 32'h0000_12F0);
		bus(1'b1, nvirq_pkg::OFS_GATE, 32'h1);
		take(5'd4);
		rdc(nvirq_pkg::OFS_GATE_PREV, 32'h1);
		done(5'd4);
		// Pend of a disabled source, then unpend discards it
		bus(1'b1, nvirq_pkg::OFS_EN_CLR, 32'h0000_0200);
		rdc(nvirq_pkg::OFS_EN_SET, 32'h0000_10F0);
		bus(1'b1, nvirq_pkg::OFS_PEND_SET, 32'h0000_0200);
		none();
		rdc(nvirq_pkg::OFS_PEND_SET, 32'h0000_0200);
		bus(1'b1, nvirq_pkg::OFS_PEND_CLR, 32'h0000_0200);
		rdc(nvirq_pkg::OFS_PEND_SET, 32'h0);
		bus(1'b1, nvirq_pkg::OFS_EN_SET, 32'h0000_0200);
		none();
		// Live line held pending while the core stalls
		ack_en <= 1'b0;
		irq_src <= 32'h0000_1000;
		repeat (4) @(posedge clk);
		rdc(nvirq_pkg::OFS_PEND_SET, 32'h0000_1000);
		ack_en <= 1'b1;
		take(5'd12);
		irq_src <= 32'h0;
		rdc(nvirq_pkg::OFS_PEND_SET, 32'h0);
		rdc(nvirq_pkg::OFS_ACTIVE, 32'h0000_1000);
		done(5'd12);
		chk(thread_ok, 1'b1);
		finish_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule : tb_top
